// ---- hdl/ppd_regs.v ----
// axi4-lite register bank for port I pullups and pad high-drive enables
`timescale 1ns/1ns
`include "ppd_defs.vh"
module ppd_regs (
   aclk,
   aresetn,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready,
   port_i_out_en,
   port_i_in_en,
   port_i_pull_act_q,
   port_i_pull_en_q,
   high_drive_en_q
);
   input  wire                     aclk;
   input  wire                     aresetn;
   input  wire [31:0]              s_axi_awaddr;
   input  wire                     s_axi_awvalid;
   output reg                      s_axi_awready;
   input  wire [31:0]              s_axi_wdata;
   input  wire [3:0]               s_axi_wstrb;
   input  wire                     s_axi_wvalid;
   output reg                      s_axi_wready;
   output reg  [1:0]               s_axi_bresp;
   output reg                      s_axi_bvalid;
   input  wire                     s_axi_bready;
   input  wire [31:0]              s_axi_araddr;
   input  wire                     s_axi_arvalid;
   output reg                      s_axi_arready;
   output reg  [31:0]              s_axi_rdata;
   output reg  [1:0]               s_axi_rresp;
   output reg                      s_axi_rvalid;
   input  wire                     s_axi_rready;
   input  wire [`PPD_PULL_W-1:0]   port_i_out_en;
   input  wire [`PPD_PULL_W-1:0]   port_i_in_en;
   output wire [`PPD_PULL_W-1:0]   port_i_pull_act_q;
   output wire [`PPD_PULL_W-1:0]   port_i_pull_en_q;
   output wire [`PPD_HDRV_W-1:0]   high_drive_en_q;

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   reg  [`PPD_PULL_W-1:0]  pull_q;
   reg  [`PPD_HDRV_W-1:0]  hdrv_q;
   reg                     aw_got_q;
   reg                     w_got_q;
   reg  [`PPD_ADDR_W-1:0]  aw_addr_q;
   reg  [31:0]             wdata_q;
   reg  [3:0]              wstrb_q;
   // base match of a held address, and the next values of the bank
   reg                     aw_base_q;
   reg  [`PPD_PULL_W-1:0]  pull_d;
   reg  [`PPD_HDRV_W-1:0]  hdrv_d;
   reg  [31:0]             rdata_d;
   reg  [1:0]              rresp_d;

   assign port_i_pull_en_q = pull_q;
   assign high_drive_en_q  = hdrv_q;

   // ----------------------------------------------------------------------
   // write channel: address and data taken in either order
   // ----------------------------------------------------------------------
   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire  = s_axi_wvalid & s_axi_wready;
   wire aw_have = aw_got_q | aw_fire;
   wire w_have  = w_got_q | w_fire;
   wire [`PPD_ADDR_W-1:0] wa = aw_got_q ? aw_addr_q
                               : s_axi_awaddr[`PPD_ADDR_W-1:0];
   wire [31:0] wd = w_got_q ? wdata_q : s_axi_wdata;
   wire [3:0]  ws = w_got_q ? wstrb_q : s_axi_wstrb;
   wire do_wr  = aw_have & w_have & ~s_axi_bvalid;
   wire wa_pull = (wa[`PPD_ADDR_W-1:2] == `PPD_OFF_PULLUP_I >> 2);
   wire wa_hdrv = (wa[`PPD_ADDR_W-1:2] == `PPD_OFF_HDRV >> 2);
   // a held address was judged against the base when it was taken
   wire wa_base = aw_got_q ? aw_base_q
                  : (s_axi_awaddr[31:`PPD_ADDR_W] ==
                     `PPD_BASE_ADDR >> `PPD_ADDR_W);
   wire wa_hit  = (wa_pull | wa_hdrv) & wa_base;
   // a write lands only on a mapped word with lane 0 strobed
   wire wr_pull = do_wr & wa_hit & wa_pull & ws[0];
   wire wr_hdrv = do_wr & wa_hit & wa_hdrv & ws[0];

   // ----------------------------------------------------------------------
   // next enable values
   // ----------------------------------------------------------------------
   // reserved bits have no storage, so writes to them simply fall away
   always @* begin
      pull_d = pull_q;
      hdrv_d = hdrv_q;
      if (wr_pull)
         pull_d = wd[`PPD_PULL_W-1:0];
      // only byte lane 0 carries writable bits
      if (wr_hdrv) begin
         hdrv_d[`PPD_HD_PORT_H_PIN_1] = wd[`PPD_HD_PORT_H_PIN_1];
         hdrv_d[`PPD_HD_PORT_H_PIN_0] = wd[`PPD_HD_PORT_H_PIN_0];
         hdrv_d[`PPD_HD_PORT_E_PIN_1] = wd[`PPD_HD_PORT_E_PIN_1];
         hdrv_d[`PPD_HD_PORT_E_PIN_0] = wd[`PPD_HD_PORT_E_PIN_0];
         hdrv_d[`PPD_HD_PORT_D_PIN_1] = wd[`PPD_HD_PORT_D_PIN_1];
         hdrv_d[`PPD_HD_PORT_D_PIN_0] = wd[`PPD_HD_PORT_D_PIN_0];
         hdrv_d[`PPD_HD_PORT_B_PIN_5] = wd[`PPD_HD_PORT_B_PIN_5];
         hdrv_d[`PPD_HD_PORT_B_PIN_4] = wd[`PPD_HD_PORT_B_PIN_4];
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PPD_RESP_OKAY;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         aw_addr_q     <= {`PPD_ADDR_W{1'b0}};
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         aw_base_q     <= 1'b0;
      end else begin
         if (aw_fire) begin
            aw_addr_q     <= s_axi_awaddr[`PPD_ADDR_W-1:0];
            aw_base_q     <= (s_axi_awaddr[31:`PPD_ADDR_W] ==
                              `PPD_BASE_ADDR >> `PPD_ADDR_W);
            s_axi_awready <= 1'b0;
         end
         if (w_fire) begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         aw_got_q <= aw_have & ~do_wr;
         w_got_q  <= w_have & ~do_wr;
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wa_hit ? `PPD_RESP_OKAY : `PPD_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // enable registers: move only on an accepted write or on reset
   // ----------------------------------------------------------------------
   // kept apart from the bus logic so that nothing else can move them
   always @(posedge aclk) begin
      if (!aresetn) begin
         pull_q <= `PPD_PULL_RST;
         hdrv_q <= `PPD_HDRV_RST;
      end else begin
         pull_q <= pull_d;
         hdrv_q <= hdrv_d;
      end
   end

   // ----------------------------------------------------------------------
   // read channel: one cycle from address to data
   // ----------------------------------------------------------------------
   wire [`PPD_ADDR_W-1:0] ra = s_axi_araddr[`PPD_ADDR_W-1:0];
   wire ra_base = (s_axi_araddr[31:`PPD_ADDR_W] ==
                   `PPD_BASE_ADDR >> `PPD_ADDR_W);
   wire ra_pull = ra_base & (ra[`PPD_ADDR_W-1:2] == `PPD_OFF_PULLUP_I >> 2);
   wire ra_hdrv = ra_base & (ra[`PPD_ADDR_W-1:2] == `PPD_OFF_HDRV >> 2);

   // unmapped words read zero and answer with an error
   always @* begin
      rdata_d = 32'h00000000;
      rresp_d = `PPD_RESP_OKAY;
      case ({ra_hdrv, ra_pull})
         2'h1: rdata_d = {25'h0000000, pull_q};
         2'h2: rdata_d = {24'h000000, hdrv_q};
         default: rresp_d = `PPD_RESP_SLVERR;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `PPD_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= rresp_d;
            s_axi_rdata   <= rdata_d;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // pullup applied only to pins acting as inputs
   // ----------------------------------------------------------------------
   ppd_pull_gate u_gate (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pull_en    (pull_q),
      .pin_out_en (port_i_out_en),
      .pin_in_en  (port_i_in_en),
      .pull_act_q (port_i_pull_act_q)
   );
endmodule // ppd_regs

// ---- hdl/ppd_defs.vh ----
// constants for the pad pullup and high-drive control register bank
//
// Notes on behaviour
// - bits 31 to 7 of the port I pullup register are reserved and read zero.
// - bits 6 to 0 of the port I pullup register each enable one pin pullup.
// - a pullup bit acts only while its pin is an input, not output or hi-z.
// - the high-drive register is decoded at offset 14h from the port base.
// - bits 31 to 8 of the high-drive register are reserved and read zero.
// - high-drive bits 7 and 6 enable strong drive on port H pins 1 and 0.
// - high-drive bits 5 to 2 enable strong drive on port E 1, E 0, D 1, D 0.
// - high-drive bits 1 and 0 enable strong drive on port B pins 5 and 4.
`ifndef PPD_DEFS_VH
`define PPD_DEFS_VH

// ----------------------------------------------------------------------
// register map (byte offsets within the port block)
// ----------------------------------------------------------------------
`define PPD_BASE_ADDR     32'h40049000
`define PPD_OFF_PULLUP_I  8'h10
`define PPD_OFF_HDRV      8'h14
`define PPD_ADDR_W        8

// ----------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------
`define PPD_PULL_W        7
`define PPD_HDRV_W        8
`define PPD_PULL_RST      7'h00
`define PPD_HDRV_RST      8'h00
`define PPD_HD_PORT_H_PIN_1  7
`define PPD_HD_PORT_H_PIN_0  6
`define PPD_HD_PORT_E_PIN_1  5
`define PPD_HD_PORT_E_PIN_0  4
`define PPD_HD_PORT_D_PIN_1  3
`define PPD_HD_PORT_D_PIN_0  2
`define PPD_HD_PORT_B_PIN_5  1
`define PPD_HD_PORT_B_PIN_4  0

// ----------------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------------
`define PPD_RESP_OKAY     2'h0
`define PPD_RESP_SLVERR   2'h2

`endif

// ---- hdl/ppd_pull_gate.v ----
// per-pin pullup gating by pin direction
`timescale 1ns/1ns
`include "ppd_defs.vh"
module ppd_pull_gate (
   aclk,
   aresetn,
   pull_en,
   pin_out_en,
   pin_in_en,
   pull_act_q
);
   input  wire                     aclk;
   input  wire                     aresetn;
   input  wire [`PPD_PULL_W-1:0]   pull_en;
   input  wire [`PPD_PULL_W-1:0]   pin_out_en;
   input  wire [`PPD_PULL_W-1:0]   pin_in_en;
   output reg  [`PPD_PULL_W-1:0]   pull_act_q;

   genvar g;
   generate
      for (g = 0; g < `PPD_PULL_W; g = g + 1) begin : g_pin
         // a pin not driven and with input buffer on is an input
         always @(posedge aclk) begin
            if (!aresetn) begin
               pull_act_q[g] <= 1'b0;
            end else begin
               pull_act_q[g] <= pull_en[g] & ~pin_out_en[g]
                                & pin_in_en[g];
            end
         end
      end
   endgenerate
endmodule // ppd_pull_gate

// ---- dv/ppd_regs_assertions.sv ----
// assertion checker for the pad pullup and high-drive register bank
`timescale 1ns/1ns
module ppd_regs_chk (
   input wire        aclk,
   input wire        aresetn,
   input wire [31:0] s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0]  s_axi_wstrb,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire [31:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire [6:0]  port_i_out_en,
   input wire [6:0]  port_i_in_en,
   input wire [6:0]  port_i_pull_act_q,
   input wire [6:0]  port_i_pull_en_q,
   input wire [7:0]  high_drive_en_q
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_aw_w_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_pull_rd;
      s_ar_take ##0 s_axi_araddr == 32'h40049010
      |=> s_axi_rvalid && s_axi_rdata == {25'h0, $past(port_i_pull_en_q)};
   endproperty
   property p_hd_rd;
      s_ar_take ##0 s_axi_araddr == 32'h40049014
      |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(high_drive_en_q)};
   endproperty
   property p_pull_wr;
      s_aw_w_take ##0 s_axi_awaddr == 32'h40049010 && s_axi_wstrb[0]
      |=> port_i_pull_en_q == $past(s_axi_wdata[6:0]) && s_axi_bvalid;
   endproperty
   property p_hd_wr;
      s_aw_w_take ##0 s_axi_awaddr == 32'h40049014 && s_axi_wstrb[0]
      |=> high_drive_en_q == $past(s_axi_wdata[7:0]) && s_axi_bresp == 2'h0;
   endproperty
   property p_nostrb;
      s_aw_w_take ##0 !s_axi_wstrb[0]
      |=> $stable(high_drive_en_q) && $stable(port_i_pull_en_q);
   endproperty
   // enables may move only on the edge that completes a write
   property p_hold;
      !$rose(s_axi_bvalid)
      |-> $stable(high_drive_en_q) && $stable(port_i_pull_en_q);
   endproperty
   property p_act;
      s_axi_rvalid || 1'h1 |=> port_i_pull_act_q ==
         $past(port_i_pull_en_q & ~port_i_out_en & port_i_in_en);
   endproperty
   property p_act_off;
      port_i_out_en == 7'h7F || port_i_in_en == 7'h00
      |=> port_i_pull_act_q == 7'h00;
   endproperty
   a_pull_rd: assert property (p_pull_rd) else $error("pull read bad");
   a_hd_rd: assert property (p_hd_rd) else $error("drive read bad");
   a_pull_wr: assert property (p_pull_wr) else $error("pull write");
   a_hd_wr: assert property (p_hd_wr) else $error("drive write");
   a_nostrb: assert property (p_nostrb) else $error("masked write");
   a_hold: assert property (p_hold) else $error("enable moved");
   a_act: assert property (p_act) else $error("pullup gating");
   a_act_off: assert property (p_act_off) else $error("pullup on");
endmodule // ppd_regs_chk

bind ppd_regs ppd_regs_chk u_chk (
   .aclk              (aclk),
   .aresetn           (aresetn),
   .s_axi_awaddr      (s_axi_awaddr),
   .s_axi_awvalid     (s_axi_awvalid),
   .s_axi_awready     (s_axi_awready),
   .s_axi_wdata       (s_axi_wdata),
   .s_axi_wstrb       (s_axi_wstrb),
   .s_axi_wvalid      (s_axi_wvalid),
   .s_axi_wready      (s_axi_wready),
   .s_axi_bresp       (s_axi_bresp),
   .s_axi_bvalid      (s_axi_bvalid),
   .s_axi_araddr      (s_axi_araddr),
   .s_axi_arvalid     (s_axi_arvalid),
   .s_axi_arready     (s_axi_arready),
   .s_axi_rdata       (s_axi_rdata),
   .s_axi_rvalid      (s_axi_rvalid),
   .port_i_out_en     (port_i_out_en),
   .port_i_in_en      (port_i_in_en),
   .port_i_pull_act_q (port_i_pull_act_q),
   .port_i_pull_en_q  (port_i_pull_en_q),
   .high_drive_en_q   (high_drive_en_q)
);

// ---- dv/pad_pullup_drive_ctrl_tb.sv ----
// self-checking bench for the pad pullup and high-drive register bank
`timescale 1ns/1ns
module pad_pullup_drive_ctrl_tb;
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, a = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0;
   logic [6:0]  port_i_out_en = 7'h0, port_i_in_en = 7'h0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire         s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [6:0]  port_i_pull_act_q, port_i_pull_en_q;
   wire  [7:0]  high_drive_en_q;
   int          failures = 0, cmp_count = 0, seed = 8523, pu = 0, hd = 0;

   ppd_regs u_dut (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .s_axi_awaddr      (s_axi_awaddr),
      .s_axi_awvalid     (s_axi_awvalid),
      .s_axi_awready     (s_axi_awready),
      .s_axi_wdata       (s_axi_wdata),
      .s_axi_wstrb       (s_axi_wstrb),
      .s_axi_wvalid      (s_axi_wvalid),
      .s_axi_wready      (s_axi_wready),
      .s_axi_bresp       (s_axi_bresp),
      .s_axi_bvalid      (s_axi_bvalid),
      .s_axi_bready      (s_axi_bready),
      .s_axi_araddr      (s_axi_araddr),
      .s_axi_arvalid     (s_axi_arvalid),
      .s_axi_arready     (s_axi_arready),
      .s_axi_rdata       (s_axi_rdata),
      .s_axi_rresp       (s_axi_rresp),
      .s_axi_rvalid      (s_axi_rvalid),
      .s_axi_rready      (s_axi_rready),
      .port_i_out_en     (port_i_out_en),
      .port_i_in_en      (port_i_in_en),
      .port_i_pull_act_q (port_i_pull_act_q),
      .port_i_pull_en_q  (port_i_pull_en_q),
      .high_drive_en_q   (high_drive_en_q)
   );

   always #50 aclk = ~aclk;

   task chk(input string n, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   // model: only the two mapped words answer, everything else reads zero
   function automatic logic [31:0] mdl(input logic [31:0] x);
      return x == 32'h40049010 ? pu : x == 32'h40049014 ? hd : 0;
   endfunction

   function automatic logic [31:0] rsp(input logic [31:0] x);
      return x == 32'h40049010 || x == 32'h40049014 ? 32'h0 : 32'h2;
   endfunction

   task wr(input logic [31:0] x, d, input logic [3:0] s);
      @(posedge aclk);
      s_axi_awaddr <= x;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk("bresp", 32'(s_axi_bresp), rsp(x));
      if (rsp(x) == 0 && s[0]) begin
         if (x[2]) hd = d[7:0];
         else pu = d[6:0];
      end
   endtask

   task rd(input logic [31:0] x);
      @(posedge aclk);
      s_axi_araddr <= x;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk("rdata", s_axi_rdata, mdl(x));
      chk("rresp", 32'(s_axi_rresp), rsp(x));
   endtask

   task outs;
      chk("pull", 32'(port_i_pull_en_q), pu);
      chk("drive", 32'(high_drive_en_q), hd);
      chk("act", 32'(port_i_pull_act_q),
          pu & ~port_i_out_en & port_i_in_en);
   endtask

   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      outs;
      wr(32'h40049014, 32'hFFFFFFFF, 4'hF);
      // same low offset outside the port block must be refused
      wr(32'h40048014, 32'h000000AA, 4'hF);
      rd(32'h40048014);
      outs;
      for (int i = 0; i < 300; i++) begin
         a = 32'h40049010 + 4 * ($unsigned($random(seed)) % 4);
         wr(a, $random(seed), 4'($random(seed)));
         port_i_out_en <= 7'($random(seed));
         port_i_in_en <= 7'($random(seed));
         rd(32'h40049010 + 4 * ($unsigned($random(seed)) % 4));
         outs;
      end
      // a reset in mid-run must clear every enable
      aresetn <= 1'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      pu = 0;
      hd = 0;
      outs;
      rd(32'h40049014);
      test_done;
   end

   // hang guard: the sequence needs well under ten thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      test_done;
   end
endmodule // pad_pullup_drive_ctrl_tb
